// file: include/eel_pkg.sv
// shared constants and types of the edge event line controller
package eel_pkg;
    localparam int EEL_LINES = 19;
    localparam int EEL_PIN_LINES = 16;
    localparam int EEL_PINS = 51;
    localparam int EEL_SEL_W = 6;
    localparam int EEL_LINE_STD = 16;
    localparam int EEL_LINE_RTC = 17;
    localparam int EEL_LINE_USB = 18;
    localparam logic [7:0] EEL_OFS_INT_MASK = 8'h00;
    localparam logic [7:0] EEL_OFS_EVT_MASK = 8'h04;
    localparam logic [7:0] EEL_OFS_RISE = 8'h08;
    localparam logic [7:0] EEL_OFS_FALL = 8'h0c;
    localparam logic [7:0] EEL_OFS_SWTRIG = 8'h10;
    localparam logic [7:0] EEL_OFS_PEND = 8'h14;
    localparam logic [7:0] EEL_OFS_SEL_BASE = 8'h20;
    localparam logic [7:0] EEL_OFS_IRQ_STAT = 8'h60;
    localparam logic [7:0] EEL_OFS_IRQ_MASK = 8'h64;
    localparam logic [18:0] EEL_RST_LINES = 19'h0_0000;
    localparam logic [5:0] EEL_RST_SEL = 6'h00;
    localparam logic [1:0] EEL_RST_IRQ = 2'h0;
    localparam int EEL_IRQ_PEND = 0;
    localparam int EEL_IRQ_OVR = 1;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } eel_bus_req_t;
    typedef struct packed {
        logic [18:0] rise;
        logic [18:0] fall;
    } eel_trig_t;
endpackage : eel_pkg

// file: hdl/eel_edge_catch.sv
// one line's asynchronous edge catcher and synchroniser
`timescale 1ns/10ps
`default_nettype none
module eel_edge_catch (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic line_i,
    input wire logic rise_en_i,
    input wire logic fall_en_i,
    input wire logic ack_i,
    output logic hit_o
);
    logic rise_cap_q;
    logic fall_cap_q;
    logic [1:0] rise_sync_q;
    logic [1:0] fall_sync_q;
    logic rise_seen_q;
    logic fall_seen_q;
    logic rise_old_q;
    logic fall_old_q;
    logic rise_clr;
    logic fall_clr;
    // the line itself clocks the capture, so a pulse shorter than clk period is held
    always_ff @(posedge line_i or posedge rise_clr) begin
        if (rise_clr) begin
            rise_cap_q <= 1'b0;
        end else begin
            rise_cap_q <= 1'b1;
        end
    end
    always_ff @(negedge line_i or posedge fall_clr) begin
        if (fall_clr) begin
            fall_cap_q <= 1'b0;
        end else begin
            fall_cap_q <= 1'b1;
        end
    end
    // capture released once its synchronised copy stands; an edge in that window merges
    assign rise_clr = rst_i | rise_sync_q[1];
    assign fall_clr = rst_i | fall_sync_q[1];
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rise_sync_q <= 2'b00;
            fall_sync_q <= 2'b00;
            rise_old_q <= 1'b0;
            fall_old_q <= 1'b0;
            rise_seen_q <= 1'b0;
            fall_seen_q <= 1'b0;
        end else begin
            rise_sync_q <= {rise_sync_q[0], rise_cap_q};
            fall_sync_q <= {fall_sync_q[0], fall_cap_q};
            rise_old_q <= rise_sync_q[1];
            fall_old_q <= fall_sync_q[1];
            // one pulse per capture, however long the synchronised copy stands
            rise_seen_q <= rise_sync_q[1] & ~rise_old_q;
            fall_seen_q <= fall_sync_q[1] & ~fall_old_q;
        end
    end
    // trigger select per line
    assign hit_o = (rise_seen_q & rise_en_i) | (fall_seen_q & fall_en_i);
    logic unused_ack;
    assign unused_ack = ack_i;
endmodule : eel_edge_catch
`default_nettype wire

// file: hdl/eel_ctrl.sv
// edge event line controller top: line select, pending, masks, registers
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module eel_ctrl
    import eel_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [EEL_PINS-1:0] pin_i,
    input wire logic supply_threshold_detector_i,
    input wire logic rtc_alarm_i,
    input wire logic usb_wakeup_i,
    input wire eel_bus_req_t bus_i,
    output logic [31:0] rdata_o,
    output logic [EEL_LINES-1:0] line_irq_o,
    output logic [EEL_LINES-1:0] line_evt_o,
    output logic wake_o,
    output logic irq_o
);
    logic [EEL_LINES-1:0] int_mask_q, int_mask_d;
    logic [EEL_LINES-1:0] evt_mask_q, evt_mask_d;
    eel_trig_t trig_q, trig_d;
    logic [EEL_LINES-1:0] pend_q, pend_d;
    logic [EEL_LINES-1:0] swtrig_q, swtrig_d;
    logic [EEL_SEL_W-1:0] sel_q [EEL_PIN_LINES];
    logic [EEL_SEL_W-1:0] sel_d [EEL_PIN_LINES];
    logic [1:0] irq_stat_q, irq_stat_d;
    logic [1:0] irq_mask_q, irq_mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [EEL_LINES-1:0] line_irq_q, line_evt_q;
    logic wake_q, irq_q;
    logic [EEL_LINES-1:0] line_irq_d, line_evt_d;
    logic wake_d, irq_d;
    logic [EEL_LINES-1:0] raw_line;
    logic [EEL_LINES-1:0] hit;

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
        is_addr = (a == ofs);
    endfunction : is_addr

    // pin select slot decode, shared by the write and the read path
    function automatic logic [4:0] sel_slot(input logic [7:0] a);
        sel_slot = 5'h00;
        for (int i = 0; i < EEL_PIN_LINES; i++) begin
            if (is_addr(a, EEL_OFS_SEL_BASE + 8'(4 * i))) begin
                sel_slot = {1'b1, 4'(i)};
            end
        end
    endfunction : sel_slot

    // top bit flags a hit, low bits give the line
    logic [4:0] sel_slot_w;
    assign sel_slot_w = sel_slot(bus_i.addr);

    // pin multiplexer for the sixteen pin lines; out of range selects read low
    genvar g;
    generate
        for (g = 0; g < EEL_PIN_LINES; g++) begin : g_pinline
            assign raw_line[g] = (sel_q[g] < EEL_SEL_W'(EEL_PINS)) ? pin_i[sel_q[g]] : 1'b0;
        end
    endgenerate
    assign raw_line[EEL_LINE_STD] = supply_threshold_detector_i;
    assign raw_line[EEL_LINE_RTC] = rtc_alarm_i;
    assign raw_line[EEL_LINE_USB] = usb_wakeup_i;

    generate
        for (g = 0; g < EEL_LINES; g++) begin : g_line
            eel_edge_catch u_catch (
                .clk_sys_i(clk_sys_i),
                .rst_i(rst_i),
                .line_i(raw_line[g]),
                .rise_en_i(trig_q.rise[g]),
                .fall_en_i(trig_q.fall[g]),
                .ack_i(1'b0),
                .hit_o(hit[g])
            );
        end
    endgenerate

    logic [EEL_LINES-1:0] any_hit;
    assign any_hit = hit | swtrig_q;

    always_comb begin
        int_mask_d = int_mask_q;
        evt_mask_d = evt_mask_q;
        trig_d = trig_q;
        swtrig_d = 19'h0_0000;
        sel_d = sel_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        pend_d = pend_q;
        if (bus_i.wr) begin
            if (is_addr(bus_i.addr, EEL_OFS_INT_MASK)) begin
                int_mask_d = bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_EVT_MASK)) begin
                evt_mask_d = bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_RISE)) begin
                trig_d.rise = bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_FALL)) begin
                trig_d.fall = bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_SWTRIG)) begin
                swtrig_d = bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_PEND)) begin
                pend_d = pend_q & ~bus_i.wdata[EEL_LINES-1:0];
            end else if (is_addr(bus_i.addr, EEL_OFS_IRQ_MASK)) begin
                irq_mask_d = bus_i.wdata[1:0];
            end else if (sel_slot_w[4]) begin
                sel_d[sel_slot_w[3:0]] = bus_i.wdata[EEL_SEL_W-1:0];
            end
        end
        // set wins over a same-cycle clear
        pend_d = pend_d | any_hit;
        // status clears on its own read; a same-cycle set below still wins
        if (bus_i.rd && is_addr(bus_i.addr, EEL_OFS_IRQ_STAT)) begin
            irq_stat_d = 2'h0;
        end
        // sticky summary: a hit on an interrupt-enabled line, and a hit on a line already pending
        if (|(any_hit & int_mask_q)) begin
            irq_stat_d[EEL_IRQ_PEND] = 1'b1;
        end
        if (|(any_hit & pend_q)) begin
            irq_stat_d[EEL_IRQ_OVR] = 1'b1;
        end
    end

    // read mux; data stands one cycle after the strobe, zero otherwise
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (bus_i.rd) begin
            if (is_addr(bus_i.addr, EEL_OFS_INT_MASK)) begin
                rdata_d = {13'h0000, int_mask_q};
            end else if (is_addr(bus_i.addr, EEL_OFS_EVT_MASK)) begin
                rdata_d = {13'h0000, evt_mask_q};
            end else if (is_addr(bus_i.addr, EEL_OFS_RISE)) begin
                rdata_d = {13'h0000, trig_q.rise};
            end else if (is_addr(bus_i.addr, EEL_OFS_FALL)) begin
                rdata_d = {13'h0000, trig_q.fall};
            end else if (is_addr(bus_i.addr, EEL_OFS_PEND)) begin
                rdata_d = {13'h0000, pend_q};
            end else if (is_addr(bus_i.addr, EEL_OFS_IRQ_STAT)) begin
                rdata_d = {30'h0000_0000, irq_stat_q};
            end else if (is_addr(bus_i.addr, EEL_OFS_IRQ_MASK)) begin
                rdata_d = {30'h0000_0000, irq_mask_q};
            end else if (sel_slot_w[4]) begin
                rdata_d = {26'h000_0000, sel_q[sel_slot_w[3:0]]};
            end
        end
    end

    // configuration and pending state
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            int_mask_q <= EEL_RST_LINES;
            evt_mask_q <= EEL_RST_LINES;
            trig_q <= '{rise: EEL_RST_LINES, fall: EEL_RST_LINES};
            swtrig_q <= EEL_RST_LINES;
            pend_q <= EEL_RST_LINES;
            for (int i = 0; i < EEL_PIN_LINES; i++) begin
                sel_q[i] <= EEL_RST_SEL;
            end
            irq_stat_q <= EEL_RST_IRQ;
            irq_mask_q <= EEL_RST_IRQ;
        end else begin
            int_mask_q <= int_mask_d;
            evt_mask_q <= evt_mask_d;
            trig_q <= trig_d;
            swtrig_q <= swtrig_d;
            pend_q <= pend_d;
            sel_q <= sel_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // output stage: every port leaves straight from a flop, no glitches reach the core
    always_comb begin
        line_irq_d = pend_d & int_mask_d;
        // events are one pulse per edge, taken from the hit; the hit still sets pending whatever the masks
        line_evt_d = any_hit & evt_mask_q;
        wake_d = |(any_hit & (int_mask_q | evt_mask_q));
        irq_d = |(irq_stat_d & irq_mask_d);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            line_irq_q <= EEL_RST_LINES;
            line_evt_q <= EEL_RST_LINES;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            line_irq_q <= line_irq_d;
            line_evt_q <= line_evt_d;
            wake_q <= wake_d;
            irq_q <= irq_d;
        end
    end

    assign rdata_o = rdata_q;
    assign line_irq_o = line_irq_q;
    assign line_evt_o = line_evt_q;
    assign wake_o = wake_q;
    assign irq_o = irq_q;
endmodule : eel_ctrl
`default_nettype wire

// file: verification/eel_ctrl_asserts.sv
// port assertions of the edge event line controller
`timescale 1ns/10ps
`default_nettype none
module eel_ctrl_asserts
    import eel_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire eel_bus_req_t bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic [EEL_LINES-1:0] line_irq_o,
    input wire logic [EEL_LINES-1:0] line_evt_o,
    input wire logic wake_o
);
    logic [EEL_LINES-1:0] im_q, im_d, em_q, em_d;
    // mask mirrors, so outputs can be tied to what software wrote
    always_comb begin
        im_d = im_q;
        em_d = em_q;
        if (bus_i.wr && bus_i.addr == EEL_OFS_INT_MASK) im_d = bus_i.wdata[EEL_LINES-1:0];
        if (bus_i.wr && bus_i.addr == EEL_OFS_EVT_MASK) em_d = bus_i.wdata[EEL_LINES-1:0];
    end
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            im_q <= '0;
            em_q <= '0;
        end else begin
            im_q <= im_d;
            em_q <= em_d;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == '0)
        else $error("read data outside read slot");
    a_irq_masked: assert property ((line_irq_o & ~(im_q | $past(im_q))) == '0)
        else $error("interrupt on masked line");
    a_evt_masked: assert property ((line_evt_o & ~(em_q | $past(em_q))) == '0)
        else $error("event on masked line");
    a_mask_read: assert property (bus_i.rd && bus_i.addr == EEL_OFS_INT_MASK
        |=> rdata_o == {13'h0000, $past(im_q)}) else $error("mask readback wrong");
    a_pend_read: assert property (bus_i.rd && bus_i.addr == EEL_OFS_PEND
        |=> rdata_o[31:19] == '0 && ($past(line_irq_o) & ~rdata_o[18:0]) == '0)
        else $error("pending misses active interrupt");
    a_unmapped_read: assert property (bus_i.rd && bus_i.addr == 8'h18 |=> rdata_o == '0)
        else $error("unmapped read not zero");
    a_trig_read: assert property (bus_i.rd && bus_i.addr == EEL_OFS_SWTRIG |=> rdata_o == '0)
        else $error("trigger register reads nonzero");
    a_evt_wake: assert property (|line_evt_o |-> ##[0:1] wake_o)
        else $error("event without wake");
    a_wake_masked: assert property (wake_o |-> |(im_q | em_q | $past(im_q | em_q)))
        else $error("wake with all lines masked");
endmodule : eel_ctrl_asserts
bind eel_ctrl eel_ctrl_asserts chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .line_irq_o(line_irq_o), .line_evt_o(line_evt_o), .wake_o(wake_o));
`default_nettype wire

// file: verification/eel_pin_model.sv
// pins and internal wake sources feeding the controller
`timescale 1ns/10ps
`default_nettype none
module eel_pin_model
    import eel_pkg::*;
(
    output logic [EEL_PINS-1:0] pin_o,
    output logic supply_threshold_detector_o,
    output logic rtc_alarm_o,
    output logic usb_wakeup_o
);
    logic [EEL_PINS+2:0] src = '0;
    assign {usb_wakeup_o, rtc_alarm_o, supply_threshold_detector_o, pin_o} = src;
    task automatic drive(input int idx, input logic v);
        src[idx] <= v;
    endtask : drive
    // narrower than a clock period, so started just after a rising clock edge it ends before the next one
    task automatic pulse(input int idx);
        src[idx] = ~src[idx];
        #2;
        src[idx] = ~src[idx];
    endtask : pulse
endmodule : eel_pin_model
`default_nettype wire

// file: verification/tb_edge_event_line_controller.sv
// self-checking bench of the edge event line controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin failures++; \
    $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb_edge_event_line_controller
    import eel_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    eel_bus_req_t bus = '0;
    logic [EEL_PINS-1:0] pin;
    logic std_l, rtc_l, usb_l, wake, irq, ev, wk, r, f;
    logic [31:0] rdata;
    logic [EEL_LINES-1:0] l_irq, l_evt;
    int failures = 0;
    int comparisons = 0;
    int n, p;
    logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h60, 8'h64};
    always #2.5 clk_sys_i = ~clk_sys_i;
    eel_pin_model pm_u (.pin_o(pin), .supply_threshold_detector_o(std_l), .rtc_alarm_o(rtc_l),
        .usb_wakeup_o(usb_l));
    eel_ctrl dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .pin_i(pin),
        .supply_threshold_detector_i(std_l), .rtc_alarm_i(rtc_l), .usb_wakeup_i(usb_l),
        .bus_i(bus), .rdata_o(rdata), .line_irq_o(l_irq), .line_evt_o(l_evt), .wake_o(wake),
        .irq_o(irq));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        bus <= '0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rd
    // edge on a source, then gather pulses over the sync latency
    task automatic hit(input int src, input logic v);
        @(posedge clk_sys_i);
        pm_u.drive(src, v);
        ev = 1'b0;
        wk = 1'b0;
        repeat (8) begin
            @(negedge clk_sys_i);
            ev |= |l_evt;
            wk |= wake;
        end
    endtask : hit
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    initial begin
        #100_000;
        failures++;
        complete_run();
    end
    initial begin
        void'($urandom(32'h6eb5_85e1));
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        foreach (ofs[i]) rd(ofs[i], 32'h0000_0000);
        $display("test reset values done");
        for (int m = 1; m < 4; m++) begin
            n = $urandom_range(15);
            p = $urandom_range(50);
            r = m[0];
            f = m[1];
            wr(EEL_OFS_SEL_BASE + 8'(4 * n), 32'(p));
            wr(EEL_OFS_INT_MASK, 32'h0000_0001 << n);
            wr(EEL_OFS_EVT_MASK, 32'h0000_0001 << n);
            wr(EEL_OFS_RISE, 32'(r) << n);
            wr(EEL_OFS_FALL, 32'(f) << n);
            wr(EEL_OFS_IRQ_MASK, 32'h0000_0001);
            hit(p, 1'b1);
            `CHK("evt", r, ev)
            `CHK("line_irq", r, l_irq[n])
            `CHK("irq", r, irq)
            rd(EEL_OFS_PEND, 32'(r) << n);
            rd(EEL_OFS_IRQ_STAT, 32'(r));
            repeat (2) @(negedge clk_sys_i);
            `CHK("irq", 1'b0, irq)
            wr(EEL_OFS_PEND, 32'hffff_ffff);
            hit(p, 1'b0);
            rd(EEL_OFS_PEND, 32'(f) << n);
            wr(EEL_OFS_PEND, 32'hffff_ffff);
            rd(EEL_OFS_IRQ_STAT, 32'(f));
            $display("test trigger mode %0d done", m);
        end
        wr(EEL_OFS_INT_MASK, 32'h0000_0000);
        wr(EEL_OFS_EVT_MASK, 32'h0000_0000);
        hit(p, 1'b1);
        `CHK("masked", 3'b000, {ev, wk, l_irq[n]})
        rd(EEL_OFS_PEND, 32'h0000_0001 << n);
        wr(EEL_OFS_PEND, 32'hffff_ffff);
        wr(EEL_OFS_INT_MASK, 32'h0000_0001 << n);
        @(posedge clk_sys_i);
        #1;
        pm_u.pulse(p);
        repeat (8) @(posedge clk_sys_i);
        rd(EEL_OFS_PEND, 32'h0000_0001 << n);
        $display("test mask and narrow pulse done");
        for (int k = 0; k < 3; k++) begin
            wr(EEL_OFS_PEND, 32'hffff_ffff);
            wr(EEL_OFS_RISE, 32'h0000_0001 << (16 + k));
            wr(EEL_OFS_INT_MASK, 32'h0000_0001 << (16 + k));
            hit(EEL_PINS + k, 1'b1);
            `CHK("wake", 1'b1, wk)
            rd(EEL_OFS_PEND, 32'h0000_0001 << (16 + k));
        end
        wr(8'h18, 32'hffff_ffff);
        rd(8'h18, 32'h0000_0000);
        $display("test internal lines and unmapped done");
        rd(EEL_OFS_IRQ_STAT, 32'h0000_0001);
        wr(EEL_OFS_SWTRIG, 32'h0000_0001 << 18);
        rd(EEL_OFS_IRQ_STAT, 32'h0000_0003);
        rd(EEL_OFS_PEND, 32'h0000_0001 << 18);
        wr(EEL_OFS_PEND, 32'hffff_ffff);
        wr(EEL_OFS_SEL_BASE + 8'(4 * n), 32'h0000_003f);
        repeat (8) @(posedge clk_sys_i);
        rd(EEL_OFS_SEL_BASE + 8'(4 * n), 32'h0000_003f);
        rd(EEL_OFS_PEND, 32'h0000_0001 << n);
        $display("test software trigger and select range done");
        complete_run();
    end
endmodule : tb_edge_event_line_controller
`default_nettype wire
